// *** include/drive_io_pkg.sv ***
// constants and carrier types of the drive io value mapper
package drive_io_pkg;
    // register byte offsets
    localparam logic [11:0] OFS_DIGIN = 12'h000;
    localparam logic [11:0] OFS_DIGOUT = 12'h004;
    localparam logic [11:0] OFS_CFG = 12'h008;
    localparam logic [11:0] OFS_AIN1 = 12'h00C;
    localparam logic [11:0] OFS_AIN1_BRK = 12'h010;
    localparam logic [11:0] OFS_AIN2 = 12'h014;
    localparam logic [11:0] OFS_AOUT1 = 12'h018;
    localparam logic [11:0] OFS_AOUT2 = 12'h01C;
    localparam logic [11:0] OFS_INT_STAT = 12'h020;
    localparam logic [11:0] OFS_INT_MASK = 12'h024;
    // per-bit windows, one word per bit, selected by paddr[11:6]
    localparam logic [5:0] WIN_DIGIN_BIT = 6'h01;
    localparam logic [5:0] WIN_DIGOUT_BIT = 6'h02;
    // reset values and field layout
    localparam logic [15:0] DOUT_RST = 16'h0000;
    localparam logic [15:0] DOUT_MASK = 16'hFF3F;
    localparam logic [9:0] CFG_RST = 10'h000;
    localparam logic [15:0] AOUT_RST = 16'h0000;
    localparam logic [1:0] INT_RST = 2'b00;
    localparam int INT_DIN_CHG = 0;
    localparam int INT_AIN1_BRK = 1;
    // analog scaling, percent in 0.01 % units, 12-bit converters
    localparam logic [15:0] PCT_FULL = 16'h2710;
    localparam logic [15:0] K_AIN_BIP = 16'h4E20;
    localparam logic [15:0] K_AIN_UNI = 16'h2710;
    localparam logic [15:0] K_AIN_420 = 16'h30D7;
    localparam logic [15:0] CODE_4MA = 16'h0333;
    localparam logic [15:0] CODE_3MA = 16'h0266;
    localparam logic [15:0] K_AO_UNI = 16'h068D;
    localparam logic [15:0] K_AO_420 = 16'h053E;
    localparam logic [15:0] K_AO_BIP = 16'h0347;
    // analog input 1 range codes
    typedef enum logic [1:0] {
        AIN_BIP_10V = 2'b00,
        AIN_UNI_10V = 2'b01,
        AIN_0_20MA = 2'b10,
        AIN_4_20MA = 2'b11
    } ain_rng_e;
    // analog output 1 range codes, 2'b11 acts as 0-10 V
    typedef enum logic [1:0] {
        AO_UNI_10V = 2'b00,
        AO_0_20MA = 2'b01,
        AO_4_20MA = 2'b10,
        AO_SPARE = 2'b11
    } aout1_rng_e;
    // configuration word, bits [9:0] of the cfg register
    typedef struct packed {
        logic [3:0] dio_dir;
        logic aout2_uni;
        aout1_rng_e aout1_rng;
        logic ain2_uni;
        ain_rng_e ain1_rng;
    } io_cfg_s;
    // drive-side digital outputs other than the shared terminals
    typedef struct packed {
        logic [1:0] opt_relay;
        logic [5:0] opt_out;
        logic [1:0] relay;
    } dout_pins_s;
endpackage

// *** hw/drive_io_value_mapper.sv ***
// drive io value mapper: digital words, analog scaling, apb registers
//
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps

// Notes on behaviour
// - all digital inputs read as one word
// - input word bit layout incl shared terminals
// - outputs form one word, bits individually reachable
// - output word bit layout to pins, relays
// - ain1 percent, bipolar as plus minus hundred
// - ain1 break flag only in 4-20 mA
// - ain2 percent unipolar or bipolar
// - aout1 percent maps linearly to range
// - aout2 percent maps bipolar or unipolar volts
// - ain1 range codes zero to three
module drive_io_value_mapper
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // digital input pins
    input wire logic [2:0] din_pin,
    input wire logic sto_clear_pin,
    input wire logic [5:0] opt_din_pin,
    // shared terminals, input, output, enable
    input wire logic [3:0] dio_in,
    output logic [3:0] dio_out,
    output logic [3:0] dio_oe,
    // other digital outputs
    output drive_io_pkg::dout_pins_s dout_pins,
    // analog converters on sys_clk
    input wire logic [11:0] ain1_code,
    input wire logic [11:0] ain2_code,
    output logic [11:0] aout1_code,
    output logic [1:0] aout1_mode,
    output logic [11:0] aout2_code,
    // interrupt
    output logic irq
);
    import drive_io_pkg::*;

    // shift-scale by a 12-bit fraction
    function automatic logic [15:0] scale(input logic [15:0] x, input logic [15:0] k);
        logic [31:0] p;
        p = {16'h0000, x} * {16'h0000, k};
        scale = p[27:12];
    endfunction

    // state
    logic [2:0] fill_r;
    logic [13:0] sync1_r;
    logic [13:0] sync2_r;
    logic [15:0] din_word_r;
    logic [15:0] dout_r;
    logic [15:0] dout_nxt;
    io_cfg_s cfg_r;
    logic [15:0] ain1_val_r;
    logic ain1_brk_r;
    logic [15:0] ain2_val_r;
    logic [15:0] aout1_r;
    logic [15:0] aout2_r;
    logic [1:0] int_stat_r;
    logic [1:0] int_stat_nxt;
    logic [1:0] int_mask_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic [3:0] dio_out_r;
    logic [3:0] dio_oe_r;
    dout_pins_s dout_pins_r;
    logic [11:0] aout1_code_r;
    logic [1:0] aout1_mode_r;
    logic [11:0] aout2_code_r;
    logic irq_r;

    // raw input vector in word order
    wire [13:0] din_raw = {opt_din_pin, sto_clear_pin, dio_in, din_pin};

    // two-flop synchronisers then one registered word
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fill_r <= 3'b000;
            sync1_r <= 14'h0000;
            sync2_r <= 14'h0000;
            din_word_r <= 16'h0000;
        end
        else
        begin
            fill_r <= {fill_r[1:0], 1'b1};
            sync1_r <= din_raw;
            sync2_r <= sync1_r;
            din_word_r <= {2'b00, sync2_r};
        end
    end

    // input change event, held off until the word has filled after reset
    wire ev_din_chg = fill_r[2] & (|(din_word_r[13:0] ^ sync2_r));

    // apb phase decode
    wire setup = psel & ~penable;
    wire acc = psel & penable & pready_r;
    wire [3:0] bit_idx = paddr[5:2];
    wire din_bit_hit = (paddr[11:6] == WIN_DIGIN_BIT);
    wire dout_bit_hit = (paddr[11:6] == WIN_DIGOUT_BIT);
    wire is_din = (paddr == OFS_DIGIN);
    wire is_dout = (paddr == OFS_DIGOUT);
    wire is_cfg = (paddr == OFS_CFG);
    wire is_ain1 = (paddr == OFS_AIN1);
    wire is_brk = (paddr == OFS_AIN1_BRK);
    wire is_ain2 = (paddr == OFS_AIN2);
    wire is_aout1 = (paddr == OFS_AOUT1);
    wire is_aout2 = (paddr == OFS_AOUT2);
    wire is_stat = (paddr == OFS_INT_STAT);
    wire is_mask = (paddr == OFS_INT_MASK);
    wire hit = is_din | is_dout | is_cfg | is_ain1 | is_brk | is_ain2
        | is_aout1 | is_aout2 | is_stat | is_mask | din_bit_hit | dout_bit_hit;
    wire wr = acc & pwrite & hit;
    wire stat_rd = acc & ~pwrite & is_stat;

    // read data selection
    wire [31:0] rd_data =
        is_din ? {16'h0000, din_word_r} :
        is_dout ? {16'h0000, dout_r} :
        is_cfg ? {22'h000000, cfg_r} :
        is_ain1 ? {{16{ain1_val_r[15]}}, ain1_val_r} :
        is_brk ? {31'h00000000, ain1_brk_r} :
        is_ain2 ? {{16{ain2_val_r[15]}}, ain2_val_r} :
        is_aout1 ? {16'h0000, aout1_r} :
        is_aout2 ? {{16{aout2_r[15]}}, aout2_r} :
        is_stat ? {30'h00000000, int_stat_r} :
        is_mask ? {30'h00000000, int_mask_r} :
        din_bit_hit ? {31'h00000000, din_word_r[bit_idx]} :
        dout_bit_hit ? {31'h00000000, dout_r[bit_idx]} :
        32'h0000_0000;

    // apb answer, data and error fixed in the setup cycle
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end
        else
        begin
            pready_r <= setup;
            pslverr_r <= setup & ~hit; // error stands with ready only
            if (setup)
            begin
                prdata_r <= pwrite ? 32'h0000_0000 : rd_data;
            end
        end
    end

    // output word, whole or one bit, reserved bits stay zero
    always_comb
    begin
        dout_nxt = dout_r;
        if (wr && is_dout)
        begin
            dout_nxt = pwdata[15:0] & DOUT_MASK;
        end
        else if (wr && dout_bit_hit)
        begin
            dout_nxt[bit_idx] = pwdata[0] & DOUT_MASK[bit_idx];
        end
    end

    // software registers
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dout_r <= DOUT_RST;
            cfg_r <= CFG_RST;
            aout1_r <= AOUT_RST;
            aout2_r <= AOUT_RST;
            int_mask_r <= INT_RST;
        end
        else
        begin
            dout_r <= dout_nxt;
            if (wr && is_cfg)
            begin
                cfg_r <= pwdata[9:0];
            end
            if (wr && is_aout1)
            begin
                aout1_r <= pwdata[15:0];
            end
            if (wr && is_aout2)
            begin
                aout2_r <= pwdata[15:0];
            end
            if (wr && is_mask)
            begin
                int_mask_r <= pwdata[1:0];
            end
        end
    end

    // analog input 1 scaling per range
    wire [15:0] a1 = {4'h0, ain1_code};
    wire [15:0] a1_bip = scale(a1, K_AIN_BIP) - PCT_FULL;
    wire [15:0] a1_uni = scale(a1, K_AIN_UNI);
    wire a1_low = (a1 < CODE_4MA);
    wire [15:0] a1_420 = a1_low ? 16'h0000 : scale(a1 - CODE_4MA, K_AIN_420);
    wire [15:0] a1_val =
        (cfg_r.ain1_rng == AIN_BIP_10V) ? a1_bip :
        (cfg_r.ain1_rng == AIN_4_20MA) ? a1_420 : a1_uni;
    wire a1_brk = (cfg_r.ain1_rng == AIN_4_20MA) && (a1 < CODE_3MA);

    // analog input 2 scaling per range
    wire [15:0] a2 = {4'h0, ain2_code};
    wire [15:0] a2_val = cfg_r.ain2_uni ? scale(a2, K_AIN_UNI)
        : scale(a2, K_AIN_BIP) - PCT_FULL;

    // analog output 1: clamp to 0..100 %
    wire [15:0] ao1_pct = (aout1_r > PCT_FULL) ? PCT_FULL : aout1_r;
    wire [15:0] ao1_420 = CODE_4MA + scale(ao1_pct, K_AO_420);
    wire [15:0] ao1_full = scale(ao1_pct, K_AO_UNI);
    wire [15:0] ao1_code = (cfg_r.aout1_rng == AO_4_20MA) ? ao1_420 : ao1_full;

    // analog output 2: clamp to range, then map
    wire ao2_neg = aout2_r[15];
    wire [15:0] ao2_mag = ao2_neg ? 16'h0000 - aout2_r : aout2_r;
    wire [15:0] ao2_magc = (ao2_mag > PCT_FULL) ? PCT_FULL : ao2_mag;
    wire [15:0] ao2_bip = ao2_neg ? PCT_FULL - ao2_magc : PCT_FULL + ao2_magc;
    wire [15:0] ao2_uni = ao2_neg ? 16'h0000 : ao2_magc;
    wire [15:0] ao2_raw = cfg_r.aout2_uni ? scale(ao2_uni, K_AO_UNI)
        : scale(ao2_bip, K_AO_BIP);
    // full positive bipolar scale lands one past the top code, so saturate
    wire [11:0] ao2_code = (ao2_raw > 16'h0FFF) ? 12'hFFF : ao2_raw[11:0];

    // analog values and break flag
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ain1_val_r <= 16'h0000;
            ain1_brk_r <= 1'b0;
            ain2_val_r <= 16'h0000;
        end
        else
        begin
            ain1_val_r <= a1_val;
            ain1_brk_r <= a1_brk;
            ain2_val_r <= a2_val;
        end
    end

    // interrupt events, set wins over read clear
    wire ev_brk = a1_brk & ~ain1_brk_r;
    wire [1:0] ev_vec = {ev_brk, ev_din_chg};
    wire [1:0] stat_clr = stat_rd ? prdata_r[1:0] : 2'b00;

    // next interrupt status
    always_comb
    begin
        int_stat_nxt = (int_stat_r & ~stat_clr) | ev_vec;
    end

    // status and interrupt line
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            int_stat_r <= INT_RST;
            irq_r <= 1'b0;
        end
        else
        begin
            int_stat_r <= int_stat_nxt;
            irq_r <= |(int_stat_nxt & int_mask_r);
        end
    end

    // pin drivers from the output word, direction bits from cfg, analog codes and mode
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dio_out_r <= 4'h0;
            dio_oe_r <= 4'h0;
            dout_pins_r <= '0;
            aout1_code_r <= 12'h000;
            aout1_mode_r <= 2'b00;
            aout2_code_r <= 12'h000;
        end
        else
        begin
            dio_out_r <= dout_r[3:0];
            dio_oe_r <= cfg_r.dio_dir;
            dout_pins_r.relay <= dout_r[5:4];
            dout_pins_r.opt_out <= dout_r[13:8];
            dout_pins_r.opt_relay <= dout_r[15:14];
            aout1_code_r <= ao1_code[11:0];
            aout1_mode_r <= cfg_r.aout1_rng;
            aout2_code_r <= ao2_code;
        end
    end

    // outputs
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign dio_out = dio_out_r;
    assign dio_oe = dio_oe_r;
    assign dout_pins = dout_pins_r;
    assign aout1_code = aout1_code_r;
    assign aout1_mode = aout1_mode_r;
    assign aout2_code = aout2_code_r;
    assign irq = irq_r;
endmodule

// *** testbench/drive_io_value_mapper_monitor.sv ***
// bus timing and output follow checks of the io mapper
`timescale 1ns/1ps
module drive_io_value_mapper_monitor
(
    // clock, reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // outputs
    input wire logic [3:0] dio_out,
    input wire logic [3:0] dio_oe,
    input wire drive_io_pkg::dout_pins_s dout_pins,
    input wire logic [1:0] aout1_mode
);
    import drive_io_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // completed write to one offset
    sequence s_wr(logic [11:0] a);
        psel && penable && pready && pwrite && paddr == a;
    endsequence
    // bus answer and outputs after writes
    setup_gets_ready_a: assert property (psel && !penable |=> pready) else $error("no ready");
    ready_one_cycle_a: assert property (pready |=> !pready) else $error("ready held");
    err_with_ready_a: assert property (pslverr |-> pready) else $error("stray error");
    err_reads_zero_a: assert property (pslverr && !pwrite |-> prdata == 0) else $error("error data");
    relay_follow_a: assert property (s_wr(OFS_DIGOUT) |-> ##2 dout_pins.relay == $past(pwdata[5:4], 2))
        else $error("relay wrong");
    opt_follow_a: assert property (s_wr(OFS_DIGOUT) |-> ##2 {dout_pins.opt_relay, dout_pins.opt_out} ==
        $past(pwdata[15:8], 2)) else $error("option out wrong");
    dio_follow_a: assert property (s_wr(OFS_DIGOUT) |-> ##2 dio_out == $past(pwdata[3:0], 2))
        else $error("shared out wrong");
    dir_follow_a: assert property (s_wr(OFS_CFG) |-> ##2 dio_oe == $past(pwdata[9:6], 2))
        else $error("direction wrong");
    mode_follow_a: assert property (s_wr(OFS_CFG) |-> ##2 aout1_mode == $past(pwdata[4:3], 2))
        else $error("aout mode wrong");
endmodule

// *** testbench/drive_io_value_mapper_test.sv ***
// self-checking bench of the io mapper
`timescale 1ns/1ps
bind drive_io_value_mapper drive_io_value_mapper_monitor i_mon (.sys_clk, .rst_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .dio_out, .dio_oe, .dout_pins, .aout1_mode);
module drive_io_value_mapper_test;
    import drive_io_pkg::*;
    logic sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, sto_clear_pin = 0;
    logic pready, pslverr, irq, er;
    logic [11:0] paddr = 0, ain1_code = 0, ain2_code = 0, aout1_code, aout2_code;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [2:0] din_pin = 0;
    logic [5:0] opt_din_pin = 0;
    logic [3:0] dio_in = 0, dio_out, dio_oe;
    logic [1:0] aout1_mode, r;
    logic [9:0] cfg;
    dout_pins_s dout_pins;
    int err_count = 0, n_checks = 0, seed = 94, v, n, c, p;
    int cc[4] = '{0, 613, 614, 4095};
    logic [11:0] zr[4] = '{OFS_DIGOUT, OFS_CFG, OFS_AOUT1, OFS_INT_MASK};
    drive_io_value_mapper i_drive_io_value_mapper (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .din_pin, .sto_clear_pin, .opt_din_pin, .dio_in, .dio_out, .dio_oe,
        .dout_pins, .ain1_code, .ain2_code, .aout1_code, .aout1_mode, .aout2_code, .irq);
    // clock
    initial forever #5 sys_clk = ~sys_clk;
    // compare and closing report
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e)
        begin
            err_count++;
            $display("ERROR at %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // one apb transfer, held until pready
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge sys_clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1;
        for (k = 0; k < 20 && pready !== 1'b1; k++)
            @(posedge sys_clk);
        if (k == 20)
        begin
            err_count++;
            finish_test();
        end
        else
        begin
            rd = prdata;
            er = pslverr;
            psel <= 0;
            penable <= 0;
        end
    endtask
    // expected scaled values
    function automatic logic [31:0] ain_exp(input logic [1:0] g, input int x);
        if (g == 0)
            return (x * 20000 >> 12) - 10000;
        if (g == 3)
            return x < 819 ? 0 : (x - 819) * 12503 >> 12;
        return x * 10000 >> 12;
    endfunction
    function automatic logic [31:0] ao1_exp(input logic [1:0] g, input int x);
        return g == 2 ? 819 + (x * 1342 >> 12) : x * 1677 >> 12;
    endfunction
    function automatic logic [31:0] ao2_exp(input logic u, input int x);
        int t;
        t = u ? (x < 0 ? 0 : x) * 1677 >> 12 : (x + 10000) * 839 >> 12;
        return t > 4095 ? 4095 : t;
    endfunction
    // main sequence
    initial
    begin
        repeat (2) @(posedge sys_clk);
        rst_n <= 1;
        foreach (zr[i])
        begin
            bus(0, zr[i], 0);
            chk(rd, 0);
        end
        repeat (4)
        begin
            v = $random(seed);
            {opt_din_pin, sto_clear_pin, dio_in, din_pin} <= v[13:0];
            repeat (4) @(posedge sys_clk);
            bus(0, OFS_DIGIN, 0);
            chk(rd, v & 32'h0000_3FFF);
            for (n = 0; n < 16; n++)
            begin
                bus(0, 12'(12'h040 + 4 * n), 0);
                chk(rd, ((v & 32'h0000_3FFF) >> n) & 1);
            end
        end
        repeat (3)
        begin
            v = $random(seed);
            bus(1, OFS_DIGOUT, v);
            repeat (3) @(posedge sys_clk);
            chk({dout_pins, dio_out}, {v[15:8], v[5:0]});
            bus(0, OFS_DIGOUT, 0);
            chk(rd, v & 32'h0000_FF3F);
        end
        v = v & 32'h0000_FF3F;
        for (n = 0; n < 16; n++)
        begin
            bus(1, 12'(12'h080 + 4 * n), (~v >> n) & 1);
            v = (v ^ (1 << n)) & 32'h0000_FF3F;
            bus(0, OFS_DIGOUT, 0);
            chk(rd, v);
        end
        for (n = 0; n < 20; n++)
        begin
            r = n[1:0];
            v = $random(seed);
            c = n < 16 ? cc[n >> 2] : v[11:0];
            p = n < 4 ? 10000 : v[30:16] % 10001;
            cfg = {v[3:0], r[0], r, r[0], r};
            ain1_code <= 12'(c);
            ain2_code <= 12'(4095 - c);
            bus(1, OFS_CFG, 32'(cfg));
            bus(1, OFS_AOUT1, p);
            bus(1, OFS_AOUT2, 2 * p - 10000);
            repeat (3) @(posedge sys_clk);
            chk(dio_oe, v[3:0]);
            chk(aout1_mode, r);
            chk(aout1_code, ao1_exp(r, p));
            chk(aout2_code, ao2_exp(r[0], 2 * p - 10000));
            bus(0, OFS_AIN1, 0);
            chk(rd, ain_exp(r, c));
            bus(0, OFS_AIN1_BRK, 0);
            chk(rd, r == 3 && c < 614);
            bus(0, OFS_AIN2, 0);
            chk(rd, ain_exp({1'b0, r[0]}, 4095 - c));
        end
        // interrupt masked, unmasked, cleared by read
        bus(0, OFS_INT_STAT, 0);
        din_pin <= ~din_pin;
        repeat (8) @(posedge sys_clk);
        chk(irq, 0);
        bus(1, OFS_INT_MASK, 1);
        repeat (3) @(posedge sys_clk);
        chk(irq, 1);
        bus(0, OFS_INT_STAT, 0);
        chk(rd & 1, 1);
        repeat (3) @(posedge sys_clk);
        chk(irq, 0);
        // unmapped place refused
        bus(1, 12'h030, 32'hFFFF_FFFF);
        chk(er, 1);
        bus(0, 12'h030, 0);
        chk(er, 1);
        chk(rd, 0);
        finish_test();
    end
endmodule
